/* File: hdl/cct_params.svh */
`ifndef CCT_PARAMS_SVH
`define CCT_PARAMS_SVH

// ----------------------------------------
// register indexes (byte address = 4 x index)
// ----------------------------------------
`define CCT_IDX_CTRLA    4'h0
`define CCT_IDX_CTRLB    4'h1
`define CCT_IDX_EVCTRL   4'h4
`define CCT_IDX_INTEN    4'h5
`define CCT_IDX_INTFLAG  4'h6
`define CCT_IDX_STATUS   4'h7
`define CCT_IDX_CNTL     4'hA
`define CCT_IDX_CNTH     4'hB
`define CCT_IDX_CCMPL    4'hC
`define CCT_IDX_CCMPH    4'hD

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCT_CTRLA_EN     0
`define CCT_CTRLA_CLK    1
`define CCT_CTRLA_SYNC   4
`define CCT_CTRLA_CASC   5
`define CCT_CTRLA_STBY   6
`define CCT_CTRLB_MODE   0
`define CCT_CTRLB_OUTEN  4
`define CCT_CTRLB_INIT   5
`define CCT_CTRLB_ASYNC  6
`define CCT_EV_CAPTURE_INPUT_ENABLE    0
`define CCT_EV_EDGE      4
`define CCT_EV_FILTER    6
`define CCT_INT_CAPTURE_EVENT     0
`define CCT_INT_OVF      1

// ----------------------------------------
// reset values, write masks, counts
// ----------------------------------------
`define CCT_RST_CTRLA    8'h00
`define CCT_RST_CTRLB    8'h00
`define CCT_RST_EVCTRL   8'h00
`define CCT_RST_INTEN    8'h00
`define CCT_RST_CNT      16'h0000
`define CCT_RST_COMPARE_CAPTURE_VALUE     16'h0000
`define CCT_MASK_CTRLA   8'h7F
`define CCT_MASK_CTRLB   8'h77
`define CCT_MASK_EVCTRL  8'h51
`define CCT_MASK_INT     8'h03
`define CCT_CNT_MAX      16'hFFFF
`define CCT_FILTER_SAMPLES 4

`endif

/* File: hdl/cct_pkg.sv */
package cct_pkg;

    typedef enum logic [2:0] {
        mode_int     = 3'h0,
        mode_timeout = 3'h1,
        mode_capture_event    = 3'h2,
        mode_frq     = 3'h3,
        mode_pw      = 3'h4,
        mode_frqpw   = 3'h5,
        mode_single  = 3'h6,
        mode_pwm8    = 3'h7
    } cct_mode_t;

    typedef enum logic [2:0] {
        clk_div1  = 3'h0,
        clk_div2  = 3'h1,
        clk_typea = 3'h2,
        clk_event = 3'h7
    } cct_clock_source_select_t;

    typedef enum logic {ss_idle, ss_run} cct_ss_t;

endpackage : cct_pkg

/* File: hdl/cct_evt_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface cct_evt_if;
    logic       capture_event_raw;
    logic       filt_en;
    logic       capture_event_clean;
    logic [2:0] clk_sel;
    logic       tca_tick;
    logic       cnt_evt;
    logic       run;
    logic       tick;
    modport filt    (input capture_event_raw, filt_en, output capture_event_clean);
    modport tickgen (input clk_sel, tca_tick, cnt_evt, run, output tick);
    modport core    (output capture_event_raw, filt_en, clk_sel, tca_tick, cnt_evt, run,
                     input capture_event_clean, tick);
endinterface : cct_evt_if
`default_nettype wire

/* File: hdl/cct_filter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cct_params.svh"
module cct_filter
    import cct_pkg::*;
#(
    parameter int DEPTH = `CCT_FILTER_SAMPLES
) (
    input wire logic pclk,
    input wire logic presetn,
    cct_evt_if.filt  f
);
    if (DEPTH < 2) begin : g_bad_depth
        $error("cct_filter: DEPTH must be at least 2");
    end

    logic [DEPTH-1:0] hist_q;
    logic             clean_q;
    wire              all_hi = &hist_q;
    wire              all_lo = ~|hist_q;
    // unfiltered path keeps one flop so the filter adds exactly DEPTH cycles
    wire              clean_d = !f.filt_en ? f.capture_event_raw :
                                all_hi     ? 1'b1 :
                                all_lo     ? 1'b0 : clean_q;

    // sampled on every pclk edge, never on the divided count clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_q  <= '0;
            clean_q <= 1'b0;
        end else begin
            hist_q  <= {hist_q[DEPTH-2:0], f.capture_event_raw};
            clean_q <= clean_d;
        end
    end
    assign f.capture_event_clean = clean_q;

    property p_filt_pass;
        @(posedge pclk) disable iff (!presetn)
        (f.filt_en && all_hi) |=> f.capture_event_clean;
    endproperty
    a_filt_pass: assert property (p_filt_pass) else $error("stable high not passed");

    property p_filt_delay;
        @(posedge pclk) disable iff (!presetn)
        (f.filt_en && $rose(f.capture_event_raw) && !f.capture_event_clean) |=> (!f.capture_event_clean)[*4];
    endproperty
    a_filt_delay: assert property (p_filt_delay) else $error("filter delay short");
endmodule : cct_filter
`default_nettype wire

/* File: hdl/cct_tick.sv */
`timescale 1ns/10ps
`default_nettype none
module cct_tick
    import cct_pkg::*;
(
    input wire logic   pclk,
    input wire logic   presetn,
    cct_evt_if.tickgen t
);
    logic div_q;
    logic evt_prev_q;
    wire  evt_rise = t.cnt_evt & ~evt_prev_q;
    // reserved selections give no tick, so the counter simply stands
    wire  sel_tick = (t.clk_sel == clk_div1)  ? 1'b1 :
                     (t.clk_sel == clk_div2)  ? div_q :
                     (t.clk_sel == clk_typea) ? t.tca_tick :
                     (t.clk_sel == clk_event) ? evt_rise :
                     1'b0;
    assign t.tick = t.run & sel_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q      <= 1'b0;
            evt_prev_q <= 1'b0;
        end else begin
            div_q      <= t.run ? ~div_q : 1'b0;
            evt_prev_q <= t.cnt_evt;
        end
    end

    property p_div2;
        @(posedge pclk) disable iff (!presetn)
        (t.run && t.clk_sel == clk_div2 && t.tick) |=> !t.tick;
    endproperty
    a_div2: assert property (p_div2) else $error("half rate ticked twice");

    property p_evt_clk;
        @(posedge pclk) disable iff (!presetn)
        (t.run && t.clk_sel == clk_event) |-> (t.tick == (t.cnt_evt && !$past(t.cnt_evt)));
    endproperty
    a_evt_clk: assert property (p_evt_clk) else $error("event clock mismatch");

    property p_typea;
        @(posedge pclk) disable iff (!presetn)
        (t.run && t.clk_sel == clk_typea) |-> (t.tick == t.tca_tick);
    endproperty
    a_typea: assert property (p_typea) else $error("type-A clock not followed");
endmodule : cct_tick
`default_nettype wire

/* File: hdl/cct_timer.sv */
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "cct_params.svh"

module cct_timer
    import cct_pkg::*;
#(
    parameter int FILTER_DEPTH = `CCT_FILTER_SAMPLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [5:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_event_evt_in,
    input  wire logic        capture_event_async_in,
    input  wire logic        cnt_evt_in,
    input  wire logic        tca_tick_in,
    input  wire logic        tca_restart_in,
    input  wire logic        sleep_standby,
    input  wire logic        sleep_powerdown,
    output logic             capture_event_evt_out,
    output logic             ovf_evt_out,
    output logic             irq,
    output logic             wave_out
);
    if (FILTER_DEPTH != 4) begin : g_bad_filter
        $error("cct_timer: filter depth is fixed at four samples");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0]  ctrla_q;
    logic [7:0]  ctrlb_q;
    logic [7:0]  evctrl_q;
    logic [7:0]  inten_q;
    logic [1:0]  flags_q;
    logic [1:0]  flags_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] compare_capture_value_q;
    logic [15:0] compare_capture_value_d;
    cct_ss_t     ss_q;
    cct_ss_t     ss_d;
    logic        capture_event_dly_q;
    logic        capture_event_prev_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        capture_event_evt_q;
    logic        ovf_evt_q;
    logic        irq_q;
    logic        wave_q;

    // ----------------------------------------
    // apb slave, one wait state
    // ----------------------------------------
    function automatic logic cct_mapped(input logic [3:0] a);
        return (a == `CCT_IDX_CTRLA) || (a == `CCT_IDX_CTRLB) || (a == `CCT_IDX_EVCTRL)
            || (a == `CCT_IDX_INTEN) || (a == `CCT_IDX_INTFLAG) || (a == `CCT_IDX_STATUS)
            || (a == `CCT_IDX_CNTL)  || (a == `CCT_IDX_CNTH)  || (a == `CCT_IDX_CCMPL)
            || (a == `CCT_IDX_CCMPH);
    endfunction : cct_mapped

    wire [3:0] idx      = paddr[5:2];
    wire       access   = psel & penable;
    wire       pready_d = access & ~pready_q;
    wire       fire     = access & pready_q & cct_mapped(idx);
    wire       wr_fire  = fire & pwrite;
    wire       rd_fire  = fire & ~pwrite;
    wire [7:0] wbyte    = pwdata[7:0];

    wire wr_ctrla  = wr_fire & (idx == `CCT_IDX_CTRLA);
    wire wr_ctrlb  = wr_fire & (idx == `CCT_IDX_CTRLB);
    wire wr_evctrl = wr_fire & (idx == `CCT_IDX_EVCTRL);
    wire wr_inten  = wr_fire & (idx == `CCT_IDX_INTEN);
    wire wr_flags  = wr_fire & (idx == `CCT_IDX_INTFLAG);
    wire wr_cntl   = wr_fire & (idx == `CCT_IDX_CNTL);
    wire wr_cnth   = wr_fire & (idx == `CCT_IDX_CNTH);
    wire wr_ccmpl  = wr_fire & (idx == `CCT_IDX_CCMPL);
    wire wr_ccmph  = wr_fire & (idx == `CCT_IDX_CCMPH);
    wire rd_ccmpl  = rd_fire & (idx == `CCT_IDX_CCMPL);

    // ----------------------------------------
    // configuration decode
    // ----------------------------------------
    cct_mode_t mode;
    assign mode = cct_mode_t'(ctrlb_q[`CCT_CTRLB_MODE +: 3]);

    wire cascade = ctrla_q[`CCT_CTRLA_CASC];
    wire capture_input_enable  = evctrl_q[`CCT_EV_CAPTURE_INPUT_ENABLE];
    wire edge_b  = evctrl_q[`CCT_EV_EDGE];
    wire async_b = ctrlb_q[`CCT_CTRLB_ASYNC];
    wire running = (ss_q == ss_run);

    // standby halts unless run-in-standby; power-down always halts
    wire active = ctrla_q[`CCT_CTRLA_EN] & ~sleep_powerdown
                & ~(sleep_standby & ~ctrla_q[`CCT_CTRLA_STBY]);

    wire cap_mode = (mode == mode_capture_event) || (mode == mode_frq)
                 || (mode == mode_pw)   || (mode == mode_frqpw);
    wire gated    = (mode == mode_single) || (mode == mode_timeout);
    wire count_en = ~gated | running;

    // ----------------------------------------
    // filter and count clock
    // ----------------------------------------
    cct_evt_if ev ();
    assign ev.capture_event_raw = capture_event_evt_in;
    assign ev.filt_en  = evctrl_q[`CCT_EV_FILTER];
    assign ev.clk_sel  = ctrla_q[`CCT_CTRLA_CLK +: 3];
    assign ev.tca_tick = tca_tick_in;
    assign ev.cnt_evt  = cnt_evt_in;
    assign ev.run      = active & count_en;

    cct_filter #(
        .DEPTH   (FILTER_DEPTH)
    ) u_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .f       (ev.filt)
    );

    cct_tick u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .t       (ev.tickgen)
    );

    wire tick = ev.tick;

    // ----------------------------------------
    // capture input edges
    // ----------------------------------------
    // the high half waits one cycle for the low half's carry, so both
    // halves see the capture on the edge where the 32-bit count is settled
    wire capture_event_sel = cascade ? capture_event_dly_q : ev.capture_event_clean;
    wire rise     = capture_event_sel & ~capture_event_prev_q;
    wire fall     = ~capture_event_sel & capture_event_prev_q;
    wire evt_ok   = active & capture_input_enable;
    wire act_edge = evt_ok & (edge_b ? fall : rise);
    wire opp_edge = evt_ok & (edge_b ? rise : fall);
    // async pulse comes from the event network's own edge catcher
    wire ss_trig  = evt_ok & ((edge_b ? (rise | fall) : rise)
                  | (async_b & capture_event_async_in));

    // ----------------------------------------
    // counter actions
    // ----------------------------------------
    wire cnt_max  = (cnt_q == `CCT_CNT_MAX);
    wire cnt_hit  = (cnt_q == compare_capture_value_q);
    wire sync_rst = active & ctrla_q[`CCT_CTRLA_SYNC] & tca_restart_in;

    wire capture_event_latch = ((mode == mode_capture_event) | (mode == mode_frq)) & act_edge
                    | ((mode == mode_pw) | (mode == mode_frqpw)) & opp_edge;
    wire restart_e  = ((mode == mode_frq) | (mode == mode_pw)) & act_edge;
    wire period_hit = (mode == mode_int) & tick & cnt_hit;
    wire ss_start   = ~running & (((mode == mode_single) & ss_trig)
                    | ((mode == mode_timeout) & act_edge));
    wire run_hit    = running & tick & cnt_hit;
    wire ss_stop    = running & (run_hit | ((mode == mode_timeout) & opp_edge) | ~gated);
    wire cnt_clear  = sync_rst | restart_e | period_hit | ss_start;
    wire wrap       = tick & cnt_max & ~cnt_clear;
    wire capture_event_set   = capture_event_latch | period_hit | run_hit;

    always_comb begin
        cnt_d = cnt_q;
        if (wr_cntl) begin
            cnt_d[7:0] = wbyte;
        end else if (wr_cnth) begin
            cnt_d[15:8] = wbyte;
        end else if (cnt_clear) begin
            cnt_d = `CCT_RST_CNT;
        end else if (tick) begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_comb begin
        compare_capture_value_d = compare_capture_value_q;
        if (wr_ccmpl) begin
            compare_capture_value_d[7:0] = wbyte;
        end else if (wr_ccmph) begin
            compare_capture_value_d[15:8] = wbyte;
        end else if (capture_event_latch) begin
            compare_capture_value_d = cnt_q;
        end
    end

    always_comb begin
        ss_d = ss_q;
        case (ss_q)
            ss_idle: begin
                if (ss_start) begin
                    ss_d = ss_run;
                end
            end
            ss_run: begin
                if (ss_stop) begin
                    ss_d = ss_idle;
                end
            end
            default: ss_d = ss_idle;
        endcase
    end

    // ----------------------------------------
    // flags, set wins over clear
    // ----------------------------------------
    wire clr_capture_event = (wr_flags & wbyte[`CCT_INT_CAPTURE_EVENT]) | (rd_ccmpl & cap_mode);
    wire clr_ovf  = wr_flags & wbyte[`CCT_INT_OVF];
    assign flags_d[`CCT_INT_CAPTURE_EVENT] = capture_event_set | (flags_q[`CCT_INT_CAPTURE_EVENT] & ~clr_capture_event);
    assign flags_d[`CCT_INT_OVF]  = wrap | (flags_q[`CCT_INT_OVF] & ~clr_ovf);

    wire wave_d = ctrlb_q[`CCT_CTRLB_OUTEN]
                & ((mode == mode_single) ? (ss_d == ss_run) : ctrlb_q[`CCT_CTRLB_INIT]);

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire [7:0] rd_val =
        (idx == `CCT_IDX_CTRLA)   ? ctrla_q :
        (idx == `CCT_IDX_CTRLB)   ? ctrlb_q :
        (idx == `CCT_IDX_EVCTRL)  ? evctrl_q :
        (idx == `CCT_IDX_INTEN)   ? inten_q :
        (idx == `CCT_IDX_INTFLAG) ? {6'h00, flags_q} :
        (idx == `CCT_IDX_STATUS)  ? {7'h00, running} :
        (idx == `CCT_IDX_CNTL)    ? cnt_q[7:0] :
        (idx == `CCT_IDX_CNTH)    ? cnt_q[15:8] :
        (idx == `CCT_IDX_CCMPL)   ? compare_capture_value_q[7:0] :
        (idx == `CCT_IDX_CCMPH)   ? compare_capture_value_q[15:8] : 8'h00;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrla_q  <= `CCT_RST_CTRLA;
            ctrlb_q  <= `CCT_RST_CTRLB;
            evctrl_q <= `CCT_RST_EVCTRL;
            inten_q  <= `CCT_RST_INTEN;
        end else begin
            if (wr_ctrla)  ctrla_q  <= wbyte & `CCT_MASK_CTRLA;
            if (wr_ctrlb)  ctrlb_q  <= wbyte & `CCT_MASK_CTRLB;
            if (wr_evctrl) evctrl_q <= wbyte & `CCT_MASK_EVCTRL;
            if (wr_inten)  inten_q  <= wbyte & `CCT_MASK_INT;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q       <= `CCT_RST_CNT;
            compare_capture_value_q      <= `CCT_RST_COMPARE_CAPTURE_VALUE;
            flags_q     <= 2'h0;
            ss_q        <= ss_idle;
            capture_event_dly_q  <= 1'b0;
            capture_event_prev_q <= 1'b0;
        end else begin
            cnt_q       <= cnt_d;
            compare_capture_value_q      <= compare_capture_value_d;
            flags_q     <= flags_d;
            ss_q        <= ss_d;
            capture_event_dly_q  <= ev.capture_event_clean;
            capture_event_prev_q <= capture_event_sel;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q   <= 32'h0000_0000;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            capture_event_evt_q <= 1'b0;
            ovf_evt_q  <= 1'b0;
            irq_q      <= 1'b0;
            wave_q     <= 1'b0;
        end else begin
            prdata_q   <= (pready_d & ~pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
            pready_q   <= pready_d;
            pslverr_q  <= pready_d & ~cct_mapped(idx);
            capture_event_evt_q <= capture_event_set;
            ovf_evt_q  <= wrap;
            irq_q      <= |(flags_q & inten_q[1:0]);
            wave_q     <= wave_d;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign capture_event_evt_out = capture_event_evt_q;
    assign ovf_evt_out  = ovf_evt_q;
    assign irq          = irq_q;
    assign wave_out     = wave_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_capture_event_latch;
        (capture_event_latch && !wr_ccmpl && !wr_ccmph) |=> (compare_capture_value_q == $past(cnt_q));
    endproperty
    a_capture_event_latch: assert property (p_capture_event_latch) else $error("capture not latched");

    property p_ovf_flag;
        wrap |=> (flags_q[`CCT_INT_OVF] && ovf_evt_out && cnt_q == 16'h0000);
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("wrap missed overflow");

    property p_evt_pulse;
        capture_event_evt_out == $past(capture_event_set);
    endproperty
    a_evt_pulse: assert property (p_evt_pulse) else $error("capture event mismatch");

    property p_irq;
        irq == |($past(flags_q) & $past(inten_q[1:0]));
    endproperty
    a_irq: assert property (p_irq) else $error("request wrong");

    property p_halt;
        (sleep_powerdown && !wr_cntl && !wr_cnth) |=> $stable(cnt_q);
    endproperty
    a_halt: assert property (p_halt) else $error("counter ran in power-down");

    property p_sync_restart;
        (sync_rst && !wr_cntl && !wr_cnth) |=> (cnt_q == 16'h0000);
    endproperty
    a_sync_restart: assert property (p_sync_restart) else $error("no sync restart");

    sequence s_clean_rise;
        cascade && $rose(ev.capture_event_clean) && !capture_event_dly_q && !capture_event_prev_q;
    endsequence
    sequence s_late_edge;
        !rise ##1 (rise && cascade);
    endsequence
    property p_chain;
        s_clean_rise |-> s_late_edge;
    endproperty
    a_chain: assert property (p_chain) else $error("chain delay wrong");

    property p_read_clear;
        (rd_ccmpl && cap_mode && !capture_event_set) |=> !flags_q[`CCT_INT_CAPTURE_EVENT];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");
endmodule : cct_timer
`default_nettype wire

/* File: tb/cct_route_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----
// event routing and type-A timer stand-in
// ----
module cct_route_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic capture_event_req,
    input  wire logic lo_ovf,
    output logic      capture_event_lo,
    output logic      capture_event_hi,
    output logic      cnt_hi,
    output logic      tca_tick,
    output logic      tca_restart
);
    logic       tca_q;
    logic [2:0] tca_cnt_q;
    // one generator feeds both halves, no skew added here
    assign capture_event_lo     = capture_event_req;
    assign capture_event_hi     = capture_event_req;
    assign cnt_hi      = lo_ovf;
    assign tca_tick    = tca_q;
    // type-A period of eight cycles, so a synced counter never passes seven
    assign tca_restart = &tca_cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tca_q     <= 1'b0;
            tca_cnt_q <= 3'h0;
        end else begin
            tca_q     <= ~tca_q;
            tca_cnt_q <= tca_cnt_q + 3'h1;
        end
    end
endmodule : cct_route_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cct_pkg::*;
    typedef struct {logic [3:0] idx; logic [7:0] rd; logic err;} cct_row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [1:0]  psel = 2'h0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [5:0]  paddr = 6'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd [2];
    logic [1:0]  pready, pslverr, capture_event_o, ovf_o, irq, wave;
    logic        capture_event_req = 1'b0;
    logic        ca = 1'b0;
    logic        sb = 1'b0;
    logic        pd = 1'b0;
    logic        capture_event_lo, capture_event_hi, cnt_hi, tca_tick, tca_restart;
    logic [31:0] r, r2;
    logic        e;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          k;
    // ----
    // masks of the writable bits, then holes in the map
    // ----
    cct_row_t rows [6] = '{'{4'h0, 8'h7F, 1'b0}, '{4'h1, 8'h77, 1'b0}, '{4'h4, 8'h51, 1'b0},
                          '{4'h5, 8'h03, 1'b0}, '{4'h2, 8'h00, 1'b1}, '{4'h8, 8'h00, 1'b1}};
    // {half, index, data}: high half first so no low wrap is lost
    logic [12:0] cfg [9] = '{13'h102F, 13'h1102, 13'h1401, 13'h0AF0, 13'h0BFF,
                             13'h0501, 13'h0102, 13'h0401, 13'h0001};

    always #2 pclk = ~pclk;

    for (genvar i = 0; i < 2; i++) begin : g
        cct_timer #(.FILTER_DEPTH(4)) dut (
            .pclk(pclk), .presetn(presetn), .psel(psel[i]), .penable(penable),
            .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rd[i]),
            .pready(pready[i]), .pslverr(pslverr[i]), .capture_event_evt_in(i ? capture_event_hi : capture_event_lo),
            .capture_event_async_in(i ? 1'b0 : ca), .cnt_evt_in(i ? cnt_hi : 1'b0), .tca_tick_in(tca_tick),
            .tca_restart_in(tca_restart), .sleep_standby(sb), .sleep_powerdown(pd),
            .capture_event_evt_out(capture_event_o[i]), .ovf_evt_out(ovf_o[i]), .irq(irq[i]), .wave_out(wave[i]));
    end

    cct_route_model rm (.pclk(pclk), .presetn(presetn), .capture_event_req(capture_event_req), .lo_ovf(ovf_o[0]),
        .capture_event_lo(capture_event_lo), .capture_event_hi(capture_event_hi), .cnt_hi(cnt_hi), .tca_tick(tca_tick),
        .tca_restart(tca_restart));

    task automatic summarize();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input int s, input logic w, input logic [3:0] idx, input logic [7:0] d);
        psel[s] <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no wait count assumed; only the bench timeout ends a stuck access
        while (pready[s] !== 1'b1) begin
            @(posedge pclk);
        end
        r = rd[s];
        e = pslverr[s];
        psel <= 2'h0;
        penable <= 1'b0;
        // an edge passes so the next call never re-drives psel in this step
        @(posedge pclk);
    endtask : apb

    // two reads of the low count byte a few cycles apart
    task automatic moves(input logic exp);
        apb(0, 1'b0, 4'hA, 8'h00);
        r2 = r;
        apb(0, 1'b0, 4'hA, 8'h00);
        chk(r !== r2, exp);
    endtask : moves

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({irq, capture_event_o, ovf_o}, 32'h0);
        foreach (rows[j]) begin
            apb(0, 1'b1, rows[j].idx, 8'hFF);
            apb(0, 1'b0, rows[j].idx, 8'h00);
            chk(r, {24'h0, rows[j].rd});
            chk(e, rows[j].err);
            apb(0, 1'b1, rows[j].idx, 8'h00);
        end
        // ----
        // chained pair: wrap of the low half, one shared capture
        // ----
        foreach (cfg[j]) begin
            apb(cfg[j][12], 1'b1, cfg[j][11:8], cfg[j][7:0]);
        end
        k = 0;
        while (ovf_o[0] !== 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        chk(k < 100, 1'b1);
        @(posedge pclk);
        chk(ovf_o[0], 1'b0);
        capture_event_req <= 1'b1;
        repeat (2) @(posedge pclk);
        capture_event_req <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(irq[0], 1'b1);
        apb(1, 1'b0, 4'hC, 8'h00);
        chk(r, 32'h1);
        apb(1, 1'b0, 4'hD, 8'h00);
        chk(r, 32'h0);
        apb(0, 1'b0, 4'hD, 8'h00);
        chk(r, 32'h0);
        apb(0, 1'b0, 4'hC, 8'h00);
        apb(0, 1'b0, 4'h6, 8'h00);
        chk(r, 32'h2);
        chk(irq[0], 1'b0);
        // ----
        // sleep and clock select
        // ----
        moves(1'b1);
        sb <= 1'b1;
        moves(1'b0);
        apb(0, 1'b1, 4'h0, 8'h41);
        moves(1'b1);
        pd <= 1'b1;
        moves(1'b0);
        sb <= 1'b0;
        pd <= 1'b0;
        apb(0, 1'b1, 4'h0, 8'h07);
        moves(1'b0);
        apb(0, 1'b1, 4'h0, 8'h03);
        moves(1'b1);
        apb(0, 1'b1, 4'h0, 8'h05);
        moves(1'b1);
        // ----
        // filter: a short glitch is dropped, a steady level is taken
        // ----
        apb(0, 1'b1, 4'h4, 8'h41);
        capture_event_req <= 1'b1;
        repeat (2) @(posedge pclk);
        capture_event_req <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(0, 1'b0, 4'h6, 8'h00);
        chk(r[0], 1'b0);
        capture_event_req <= 1'b1;
        repeat (6) @(posedge pclk);
        capture_event_req <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(0, 1'b0, 4'h6, 8'h00);
        chk(r[0], 1'b1);
        // ----
        // sync restart, then an asynchronous single shot
        // ----
        apb(0, 1'b1, 4'h0, 8'h11);
        repeat (8) @(posedge pclk);
        apb(0, 1'b0, 4'hA, 8'h00);
        chk(r < 32'h8, 1'b1);
        apb(0, 1'b1, 4'hC, 8'hFF);
        apb(0, 1'b1, 4'h1, 8'h56);
        apb(0, 1'b1, 4'h4, 8'h01);
        ca <= 1'b1;
        @(posedge pclk);
        ca <= 1'b0;
        apb(0, 1'b0, 4'h7, 8'h00);
        chk(r, 32'h1);
        chk(wave[0], 1'b1);
        summarize();
    end
endmodule : tb
`default_nettype wire
